// >>> design/nor_host_pkg.sv
package nor_host_pkg;
  // Bus widths
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  // Unlock addresses and command codes
  localparam logic [11:0] UNLOCK_A_WORD = 12'h555;
  localparam logic [11:0] UNLOCK_B_WORD = 12'h2aa;
  localparam logic [11:0] UNLOCK_A_BYTE = 12'haaa;
  localparam logic [11:0] UNLOCK_B_BYTE = 12'h555;
  localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_PROGRAM = 8'ha0;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CODE_RESUME = 8'h30;
  localparam logic [7:0] CODE_SUSPEND = 8'hb0;
  localparam logic [7:0] CODE_RESET = 8'hf0;
  localparam logic [7:0] CODE_IDENT = 8'h90;
  localparam logic [7:0] CODE_PROT_UNLOCK = 8'h20;
  // Status bit positions
  localparam int POLL_BIT_SEVEN = 7;
  localparam int TOGGLE_BIT_SIX = 6;
  localparam int TIMEOUT_BIT_FIVE = 5;
  // Address bit positions for protect control
  localparam int ADDR_BIT_SIX = 6;
  localparam int ADDR_BIT_NINE = 9;
  // Bus cycle timing: 10 MHz core clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETUP_NS = 100;
  localparam int PULSE_NS = 200;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Operation codes of the user port
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_PROGRAM = 4'h1;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h2;
  localparam logic [3:0] OP_SECTOR_ERASE = 4'h3;
  localparam logic [3:0] OP_SUSPEND = 4'h4;
  localparam logic [3:0] OP_RESUME = 4'h5;
  localparam logic [3:0] OP_RESET = 4'h6;
  localparam logic [3:0] OP_IDENT = 4'h7;
  localparam logic [3:0] OP_PROTECT = 4'h8;
  localparam logic [3:0] OP_UNPROTECT = 4'h9;
  localparam logic [3:0] OP_PROT_VERIFY = 4'ha;
endpackage : nor_host_pkg

// >>> design/nor_cycle_if.sv
`timescale 1ns/1ns
`default_nettype none
// Single bus cycle request between sequencer and cycle engine
interface nor_cycle_if;
  logic                               req;
  logic                               wr;
  logic [nor_host_pkg::ADDR_W-1:0]    addr;
  logic [nor_host_pkg::DATA_W-1:0]    wdata;
  logic                               done;
  logic [nor_host_pkg::DATA_W-1:0]    rdata;
  modport seq (output req, wr, addr, wdata, input done, rdata);
  modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface : nor_cycle_if
`default_nettype wire

// >>> design/nor_bus_cycle.sv
`timescale 1ns/1ns
`default_nettype none
// Runs one read or write cycle on the flash pins
module nor_bus_cycle (
  // Clock and reset
  input  wire logic                            core_clk_i,
  input  wire logic                            rstn_i,
  // Request side
  nor_cycle_if.eng                             cyc,
  // Flash pins
  output logic                                 ce_n_o,
  output logic                                 oe_n_o,
  output logic                                 we_n_o,
  output logic [nor_host_pkg::ADDR_W-1:0]      addr_o,
  output logic [nor_host_pkg::DATA_W-1:0]      dq_o,
  output logic                                 dq_oe_n_o,
  input  wire logic [nor_host_pkg::DATA_W-1:0] dq_i
);
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_DONE} cyc_e;
  cyc_e                            st_q, st_d;
  logic [2:0]                      cnt_q, cnt_d;
  logic                            wr_q, wr_d;
  logic [nor_host_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [nor_host_pkg::DATA_W-1:0] wd_q, wd_d;
  logic [nor_host_pkg::DATA_W-1:0] rd_q, rd_d;
  logic [nor_host_pkg::DATA_W-1:0] sync1_q, sync2_q;

  // Two-stage synchroniser on the data pins
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= dq_i;
      sync2_q <= sync1_q;
    end
  end

  // Address setup, then strobe pulse; data sampled at pulse end
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    wr_d   = wr_q;
    addr_d = addr_q;
    wd_d   = wd_q;
    rd_d   = rd_q;
    unique case (st_q)
      C_IDLE: if (cyc.req) begin
        wr_d   = cyc.wr;
        addr_d = cyc.addr;
        wd_d   = cyc.wdata;
        cnt_d  = 3'(nor_host_pkg::SETUP_CYC);
        st_d   = C_SETUP;
      end
      C_SETUP: begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1) begin
          cnt_d = 3'(nor_host_pkg::PULSE_CYC + 2);
          st_d  = C_PULSE;
        end
      end
      C_PULSE: begin
        cnt_d = cnt_q - 3'h1;
        if (cnt_q == 3'h1) begin
          rd_d = sync2_q;
          st_d = C_DONE;
        end
      end
      C_DONE: st_d = C_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      st_q   <= C_IDLE;
      cnt_q  <= '0;
      wr_q   <= 1'b0;
      addr_q <= '0;
      wd_q   <= '0;
      rd_q   <= '0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      wr_q   <= wr_d;
      addr_q <= addr_d;
      wd_q   <= wd_d;
      rd_q   <= rd_d;
    end
  end

  // Chip-select framing the cycle; write enable falls after address is stable
  assign ce_n_o    = (st_q == C_IDLE) || (st_q == C_DONE);
  assign we_n_o    = !(wr_q && st_q == C_PULSE);
  assign oe_n_o    = !(!wr_q && st_q == C_PULSE);
  assign dq_oe_n_o = !(wr_q && st_q != C_IDLE);
  assign addr_o    = addr_q;
  assign dq_o      = wd_q;
  assign cyc.done  = (st_q == C_DONE);
  assign cyc.rdata = rd_q;

  chk_write_strobe: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !we_n_o |-> !ce_n_o && oe_n_o && !dq_oe_n_o) else $error("write strobe without framing");
  chk_no_contention: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !oe_n_o |-> dq_oe_n_o && we_n_o) else $error("read while driving data");
endmodule : nor_bus_cycle
`default_nettype wire

// >>> design/nor_flash_host.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Program: two unlocks, A0, address and data
// - Address at strobe fall, data at rise
// - F0 anywhere returns to read, aborts
// - Identifier command then maker/device code reads
// - Host drives word or byte unlock addresses
// - Six-cycle protect unlock, then A6/A9 write
// - Verify read only after protect command
// - Chip erase is six writes ending 10
// - Sector erase ends 30 at sector address
module nor_flash_host (
  // Clock and reset
  input  wire logic                            core_clk_i,
  input  wire logic                            rstn_i,
  // User command port
  input  wire logic                            cmd_valid_i,
  output logic                                 cmd_ready_o,
  input  wire logic [3:0]                      cmd_op_i,
  input  wire logic [nor_host_pkg::ADDR_W-1:0] cmd_addr_i,
  input  wire logic [nor_host_pkg::DATA_W-1:0] cmd_data_i,
  input  wire logic                            byte_mode_i,
  output logic                                 rsp_valid_o,
  output logic [nor_host_pkg::DATA_W-1:0]      rsp_data_o,
  output logic                                 rsp_fail_o,
  // Flash pins
  output logic                                 ce_n_o,
  output logic                                 oe_n_o,
  output logic                                 we_n_o,
  output logic [nor_host_pkg::ADDR_W-1:0]      addr_o,
  output logic [nor_host_pkg::DATA_W-1:0]      dq_o,
  output logic                                 dq_oe_n_o,
  input  wire logic [nor_host_pkg::DATA_W-1:0] dq_i
);
  typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_POLLW, S_RESP} seq_e;
  seq_e                            st_q, st_d;
  logic [3:0]                      op_q, op_d;
  logic [2:0]                      idx_q, idx_d;
  logic [nor_host_pkg::ADDR_W-1:0] ta_q, ta_d;
  logic [nor_host_pkg::DATA_W-1:0] td_q, td_d;
  logic [nor_host_pkg::DATA_W-1:0] res_q, res_d;
  logic                            fail_q, fail_d;
  logic                            prev_ok_q, prev_ok_d;
  logic                            bm_q, bm_d;
  logic [2:0]                      len;
  logic                            step_wr;
  logic [nor_host_pkg::ADDR_W-1:0] step_a;
  logic [7:0]                      step_d;
  logic                            poll;
  logic [11:0]                     ua, ub;

  nor_cycle_if cyc ();

  nor_bus_cycle u_cycle (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .cyc        (cyc),
    .ce_n_o     (ce_n_o),
    .oe_n_o     (oe_n_o),
    .we_n_o     (we_n_o),
    .addr_o     (addr_o),
    .dq_o       (dq_o),
    .dq_oe_n_o  (dq_oe_n_o),
    .dq_i       (dq_i)
  );

  // Unlock addresses depend on bus width; upper bits left zero
  assign ua = bm_q ? nor_host_pkg::UNLOCK_A_BYTE : nor_host_pkg::UNLOCK_A_WORD;
  assign ub = bm_q ? nor_host_pkg::UNLOCK_B_BYTE : nor_host_pkg::UNLOCK_B_WORD;

  // Step table: one bus cycle per index of each operation
  always_comb begin
    len     = 3'h1;
    step_wr = 1'b1;
    step_a  = {6'h0, ua};
    step_d  = nor_host_pkg::CODE_UNLOCK1;
    poll    = 1'b0;
    if (idx_q == 3'h1 || idx_q == 3'h4) begin
      step_a = {6'h0, ub};
      step_d = nor_host_pkg::CODE_UNLOCK2;
    end
    unique case (op_q)
      nor_host_pkg::OP_READ: begin
        step_wr = 1'b0;
        step_a  = ta_q;
      end
      nor_host_pkg::OP_PROGRAM: begin
        len  = 3'h4;
        poll = 1'b1;
        if (idx_q == 3'h2) step_d = nor_host_pkg::CODE_PROGRAM;
        if (idx_q == 3'h3) begin
          step_a = ta_q;
          step_d = td_q[7:0];
        end
      end
      nor_host_pkg::OP_CHIP_ERASE, nor_host_pkg::OP_SECTOR_ERASE: begin
        len  = 3'h6;
        poll = 1'b1;
        if (idx_q == 3'h2) step_d = nor_host_pkg::CODE_ERASE_SETUP;
        if (idx_q == 3'h5) begin
          step_d = (op_q == nor_host_pkg::OP_CHIP_ERASE) ? nor_host_pkg::CODE_CHIP_ERASE
                                                         : nor_host_pkg::CODE_SECTOR_ERASE;
          if (op_q == nor_host_pkg::OP_SECTOR_ERASE) step_a = ta_q;
        end
      end
      nor_host_pkg::OP_SUSPEND: step_d = nor_host_pkg::CODE_SUSPEND;
      nor_host_pkg::OP_RESUME: step_d = nor_host_pkg::CODE_RESUME;
      nor_host_pkg::OP_RESET: step_d = nor_host_pkg::CODE_RESET;
      nor_host_pkg::OP_IDENT: begin
        len = 3'h4;
        if (idx_q == 3'h2) step_d = nor_host_pkg::CODE_IDENT;
        if (idx_q == 3'h3) begin
          step_wr = 1'b0;
          step_a  = {16'h0, 1'b0, ta_q[0]};
        end
      end
      nor_host_pkg::OP_PROTECT, nor_host_pkg::OP_UNPROTECT: begin
        len = 3'h7;
        if (idx_q == 3'h2) step_d = nor_host_pkg::CODE_ERASE_SETUP;
        if (idx_q == 3'h5) step_d = nor_host_pkg::CODE_PROT_UNLOCK;
        if (idx_q == 3'h6) begin
          step_a = ta_q;
          step_a[nor_host_pkg::ADDR_BIT_NINE] = 1'b1;
          step_a[nor_host_pkg::ADDR_BIT_SIX]  = (op_q == nor_host_pkg::OP_UNPROTECT);
          step_d = 8'h00;
        end
      end
      nor_host_pkg::OP_PROT_VERIFY: begin
        step_wr = 1'b0;
        step_a  = ta_q;
        step_a[nor_host_pkg::ADDR_BIT_NINE] = 1'b1;
        step_a[1] = 1'b1;
      end
      default: step_d = nor_host_pkg::CODE_RESET;
    endcase
  end

  // Sequencer: issue steps, then for program and erase poll the toggle bit until it settles
  always_comb begin
    st_d      = st_q;
    op_d      = op_q;
    idx_d     = idx_q;
    ta_d      = ta_q;
    td_d      = td_q;
    res_d     = res_q;
    fail_d    = fail_q;
    prev_ok_d = prev_ok_q;
    bm_d      = bm_q;
    unique case (st_q)
      S_IDLE: if (cmd_valid_i) begin
        op_d      = cmd_op_i;
        ta_d      = cmd_addr_i;
        td_d      = cmd_data_i;
        bm_d      = byte_mode_i;
        idx_d     = 3'h0;
        fail_d    = 1'b0;
        prev_ok_d = 1'b0;
        st_d      = S_ISSUE;
      end
      S_ISSUE: st_d = S_WAIT;
      S_WAIT: if (cyc.done) begin
        res_d = cyc.rdata;
        if (idx_q + 3'h1 == len) st_d = poll ? S_POLL : S_RESP;
        else begin
          idx_d = idx_q + 3'h1;
          st_d  = S_ISSUE;
        end
      end
      S_POLL: st_d = S_POLLW;
      S_POLLW: if (cyc.done) begin
        // Done once two consecutive polls agree on the toggle bit; a stale pre-poll value never counts
        if (prev_ok_q &&
            cyc.rdata[nor_host_pkg::TOGGLE_BIT_SIX] == res_q[nor_host_pkg::TOGGLE_BIT_SIX]) begin
          st_d = S_RESP;
        end else if (prev_ok_q && cyc.rdata[nor_host_pkg::TIMEOUT_BIT_FIVE] &&
                     res_q[nor_host_pkg::TIMEOUT_BIT_FIVE]) begin
          // Still toggling with bit5 on both reads: array data cannot fake this
          fail_d = 1'b1;
          st_d   = S_RESP;
        end else begin
          st_d = S_POLL;
        end
        prev_ok_d = 1'b1;
        res_d     = cyc.rdata;
      end
      S_RESP: begin
        st_d = S_IDLE;
        if (fail_q && op_q != nor_host_pkg::OP_RESET) begin
          op_d   = nor_host_pkg::OP_RESET;
          idx_d  = 3'h0;
          st_d   = S_ISSUE;
          fail_d = 1'b1;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      st_q      <= S_IDLE;
      op_q      <= nor_host_pkg::OP_READ;
      idx_q     <= '0;
      ta_q      <= '0;
      td_q      <= '0;
      res_q     <= '0;
      fail_q    <= 1'b0;
      prev_ok_q <= 1'b0;
      bm_q      <= 1'b0;
    end else begin
      st_q      <= st_d;
      op_q      <= op_d;
      idx_q     <= idx_d;
      ta_q      <= ta_d;
      td_q      <= td_d;
      res_q     <= res_d;
      fail_q    <= fail_d;
      prev_ok_q <= prev_ok_d;
      bm_q      <= bm_d;
    end
  end

  // Cycle requests toward the engine
  assign cyc.req   = (st_q == S_ISSUE) || (st_q == S_POLL);
  assign cyc.wr    = (st_q == S_ISSUE) && step_wr;
  assign cyc.addr  = (st_q == S_POLL) ? ta_q : step_a;
  assign cyc.wdata = (op_q == nor_host_pkg::OP_PROGRAM && idx_q == 3'h3) ? td_q : {8'h00, step_d};

  // Answer after the reset that follows a failure as well
  assign cmd_ready_o = (st_q == S_IDLE);
  assign rsp_valid_o = (st_q == S_RESP) && !(fail_q && op_q != nor_host_pkg::OP_RESET);
  assign rsp_data_o  = res_q;
  assign rsp_fail_o  = fail_q;

  sequence unlock_pair_s;
    cyc.req && cyc.wr && cyc.wdata[7:0] == nor_host_pkg::CODE_UNLOCK1 &&
    !(op_q == nor_host_pkg::OP_PROGRAM && idx_q == 3'h3);
  endsequence

  chk_unlock_addr: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    unlock_pair_s |-> cyc.addr[11:0] == ua) else $error("unlock address wrong");
  chk_program_code: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    cyc.req && op_q == nor_host_pkg::OP_PROGRAM && idx_q == 3'h2 |-> cyc.wdata[7:0] == nor_host_pkg::CODE_PROGRAM)
    else $error("program setup code wrong");
  chk_prot_a9: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    cyc.req && op_q == nor_host_pkg::OP_PROTECT && idx_q == 3'h6 |-> cyc.addr[9] && !cyc.addr[6])
    else $error("protect address wrong");
  chk_verify_addr: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    cyc.req && op_q == nor_host_pkg::OP_PROT_VERIFY |-> !cyc.wr && cyc.addr[1] && cyc.addr[9])
    else $error("verify read address wrong");
  chk_fail_reset: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    st_q == S_RESP && fail_q && op_q != nor_host_pkg::OP_RESET |=> st_q == S_ISSUE && op_q == nor_host_pkg::OP_RESET)
    else $error("no reset after failure");
  chk_resp_pulse: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rsp_valid_o |=> !rsp_valid_o) else $error("response longer than one cycle");
  chk_issue_done: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    st_q == S_ISSUE |-> ##[2:8] cyc.done) else $error("bus cycle did not finish");
  chk_erase_last: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    cyc.req && op_q == nor_host_pkg::OP_CHIP_ERASE && idx_q == 3'h5 |-> cyc.wdata[7:0] == nor_host_pkg::CODE_CHIP_ERASE)
    else $error("chip erase code wrong");
endmodule : nor_flash_host
`default_nettype wire

// >>> testbench/nor_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
// Behavioural flash device on the far side of the host pins
module nor_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h005e, // Arbitrary value
  parameter logic [15:0] DEV_CODE   = 16'h1a2b, // Arbitrary value
  parameter int          BUSY_READS = 3
) (
  // Bus strobes and address
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [17:0] addr_i,
  // Data wire level and device drive
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  // Unlock address width and forced failure
  input  wire logic        byte_mode_i,
  input  wire logic        fail_i
);
  logic [15:0] mem [logic [17:0]];
  logic        prot [logic [5:0]];
  logic [33:0] wlog [$];
  logic [17:0] a_lat = 'x;
  logic [15:0] last  = 16'h0000;
  logic [15:0] pdat  = 16'h0000;
  logic        tog   = 1'b0;
  logic [11:0] ua;
  logic [11:0] ub;
  int          step  = 0;
  int          mode  = 0; // 0 array,1 ident,2 program,3 chip erase,4 verify,5 armed,6 suspended,7 sector erase
  int          busy  = 0;
  int          viol  = 0;
  bit          hv_id = 1'b0; // High voltage on address bit nine, set by the bench
  assign ua = byte_mode_i ? 12'haaa : 12'h555;
  assign ub = byte_mode_i ? 12'h555 : 12'h2aa;
  // Drives the last read value in a read cycle, else its complement
  assign dq_o = (!ce_n_i && !oe_n_i && we_n_i) ? last : ~last;
  // Command interpreter; busy phases take only their few codes
  task automatic write_cmd(input logic [17:0] a, input logic [15:0] d);
    logic [7:0] c;
    logic       hit_a;
    logic       hit_b;
    c = d[7:0];
    hit_a = (a[11:0] == ua);
    hit_b = (a[11:0] == ub);
    if (mode inside {2, 3, 7}) begin
      if (fail_i && c == 8'hf0) mode = 0;
      else if (mode == 7 && c == 8'hb0) mode = 6;
      return;
    end
    if (mode == 6 && c == 8'h30) begin
      mode = 7;
      return;
    end
    if (mode == 5) begin
      if (a[9] && !a[6]) prot[a[17:12]] = 1'b1;
      else if (a[9]) prot.delete();
      mode = a[9] ? 4 : 0;
      return;
    end
    mode = 0;
    busy = 0;
    case (step)
      0: step = (hit_a && c == 8'haa) ? 1 : 0;
      1: step = (hit_b && c == 8'h55) ? 2 : 0;
      2: begin
        step = (hit_a && c == 8'h80) ? 3 : (hit_a && c == 8'ha0) ? 6 : 0;
        if (hit_a && c == 8'h90) mode = 1;
      end
      3: step = (hit_a && c == 8'haa) ? 4 : 0;
      4: step = (hit_b && c == 8'h55) ? 5 : 0;
      5: begin
        step = 0;
        if (hit_a && c == 8'h10) mode = 3;
        if (hit_a && c == 8'h20) mode = 5;
        if (c == 8'h30) mode = 7;
        if (mode == 3) mem.delete();
        if (mode == 7) foreach (mem[k]) if (k[17:12] == a[17:12]) mem[k] = 16'hffff;
      end
      default: begin
        pdat = d;
        mem[a] = d;
        mode = 2;
        step = 0;
      end
    endcase
  endtask
  // Address at the falling strobe edge, data at the rising one
  always @(negedge (ce_n_i | we_n_i)) a_lat = addr_i;
  always @(posedge (ce_n_i | we_n_i)) begin
    if (!$isunknown(a_lat)) begin
      if (addr_i !== a_lat || oe_n_i !== 1'b1) viol++;
      wlog.push_back({a_lat, dq_i});
      write_cmd(a_lat, dq_i);
    end
    a_lat = 'x;
  end
  // Status while an embedded operation runs, else codes or array data
  always @(negedge (ce_n_i | oe_n_i)) begin
    if (mode inside {2, 3, 7}) begin
      tog = ~tog;
      last = {8'h00, (mode == 2) ? ~pdat[7] : 1'b0, tog, fail_i, 5'h00};
      busy++;
      if (!fail_i && busy >= BUSY_READS) mode = 0;
    end else if (hv_id && !addr_i[1]) last = addr_i[0] ? DEV_CODE : MAKER_CODE;
    else if (mode == 1) last = addr_i[0] ? DEV_CODE : MAKER_CODE;
    else if (mode == 4 && addr_i[1]) last = prot.exists(addr_i[17:12]) ? 16'h0001 : 16'h0000;
    else last = mem.exists(addr_i) ? mem[addr_i] : 16'hffff;
  end
endmodule // nor_flash_model
`default_nettype wire

// >>> testbench/nor_flash_host_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench: host controller against the flash model
module nor_flash_host_tb_top;
  localparam logic [15:0] MAKER = 16'h005e; // Arbitrary value
  localparam logic [15:0] DEV   = 16'h1a2b; // Arbitrary value
  logic        core_clk_i = 1'b0;
  logic        rstn_i     = 1'b0;
  logic        cmd_valid  = 1'b0;
  logic [3:0]  cmd_op     = 4'h0;
  logic [17:0] cmd_addr   = 18'h00000;
  logic [15:0] cmd_data   = 16'h0000;
  logic        byte_mode  = 1'b0;
  logic        fail_mode  = 1'b0;
  logic        cmd_ready, rsp_valid, rsp_fail, ce_n, oe_n, we_n, dq_oe_n;
  logic [15:0] rsp_data, host_dq, flash_dq, dq_bus;
  logic [17:0] addr;
  int          fails   = 0;
  int          n_tests = 0;
  // Wire level: host drives while its enable is low
  assign dq_bus = dq_oe_n ? flash_dq : host_dq;
  nor_flash_host u_dut (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .cmd_valid_i (cmd_valid),
    .cmd_ready_o (cmd_ready),
    .cmd_op_i    (cmd_op),
    .cmd_addr_i  (cmd_addr),
    .cmd_data_i  (cmd_data),
    .byte_mode_i (byte_mode),
    .rsp_valid_o (rsp_valid),
    .rsp_data_o  (rsp_data),
    .rsp_fail_o  (rsp_fail),
    .ce_n_o      (ce_n),
    .oe_n_o      (oe_n),
    .we_n_o      (we_n),
    .addr_o      (addr),
    .dq_o        (host_dq),
    .dq_oe_n_o   (dq_oe_n),
    .dq_i        (dq_bus)
  );
  nor_flash_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEV), .BUSY_READS(3)) u_flash (
    .ce_n_i      (ce_n),
    .oe_n_i      (oe_n),
    .we_n_i      (we_n),
    .addr_i      (addr),
    .dq_i        (dq_bus),
    .dq_o        (flash_dq),
    .byte_mode_i (byte_mode),
    .fail_i      (fail_mode)
  );
  // 10 MHz clock
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  task automatic end_sim;
    $display("Checks: %0d, mismatches: %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // One user request, then wait for its response pulse
  task automatic op(input logic [3:0] o, input logic [17:0] a, input logic [15:0] d);
    int n;
    n = 0;
    u_flash.wlog.delete();
    @(negedge core_clk_i);
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge core_clk_i);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_op = o;
    cmd_addr = a;
    cmd_data = d;
    @(negedge core_clk_i);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(rsp_valid, 1'b1);
  endtask
  // Logged write i; partial form keeps low address and code byte
  task automatic chk_wr(input int i, input logic [17:0] a, input logic [15:0] d, input bit full);
    logic [33:0] s;
    s = u_flash.wlog[i];
    if (full) chk(s, {a, d});
    else chk({s[27:16], s[7:0]}, {a[11:0], d[7:0]});
  endtask
  task automatic chk_unl(input int i, input logic [7:0] c);
    logic [17:0] ua;
    logic [17:0] ub;
    ua = byte_mode ? 18'haaa : 18'h555;
    ub = byte_mode ? 18'h555 : 18'h2aa;
    chk_wr(i, ua, 16'h00aa, 0);
    chk_wr(i + 1, ub, 16'h0055, 0);
    chk_wr(i + 2, ua, {8'h00, c}, 0);
  endtask
  // Program then read back
  task automatic t_program(input logic bm, input logic [17:0] a, input logic [15:0] d);
    byte_mode = bm;
    op(4'h1, a, d);
    chk(u_flash.wlog.size(), 4);
    chk_unl(0, 8'ha0);
    chk_wr(3, a, d, 1);
    chk(rsp_fail, 1'b0);
    op(4'h0, a, 16'h0000);
    chk(rsp_data, d);
    chk(u_flash.wlog.size(), 0);
  endtask
  // Erase a sector or the chip; data outside the sector tells which
  task automatic t_erase(input logic chip);
    t_program(1'b0, 18'h05010, 16'h1357);
    t_program(1'b0, 18'h21004, 16'h2468);
    op(chip ? 4'h2 : 4'h3, 18'h21000, 16'h0000);
    chk(u_flash.wlog.size(), 6);
    chk_unl(0, 8'h80);
    chk_wr(3, 18'h555, 16'h00aa, 0);
    chk_wr(4, 18'h2aa, 16'h0055, 0);
    chk_wr(5, chip ? 18'h555 : 18'h21000, chip ? 16'h0010 : 16'h0030, 0);
    if (!chip) chk(u_flash.wlog[5][33:28], 6'h21);
    chk(u_flash.mode, 0);
    chk(rsp_fail, 1'b0);
    op(4'h0, 18'h21004, 16'h0000);
    chk(rsp_data, 16'hffff);
    op(4'h0, 18'h05010, 16'h0000);
    chk(rsp_data, chip ? 16'hffff : 16'h1357);
  endtask
  // Suspend, resume, reset: one write each, array data kept
  task automatic t_single;
    logic [7:0] code [3];
    code = '{8'hb0, 8'h30, 8'hf0};
    for (int i = 0; i < 3; i++) begin
      op(4'h4 + i[3:0], 18'h00123, 16'h0000);
      chk(u_flash.wlog.size(), 1);
      chk(u_flash.wlog[0][7:0], code[i]);
    end
    op(4'h0, 18'h05010, 16'h0000);
    chk(rsp_data, 16'h1357);
  endtask
  task automatic t_ident;
    for (int b = 0; b < 2; b++) begin
      op(4'h7, {17'h00000, b[0]}, 16'h0000);
      chk_unl(0, 8'h90);
      chk(rsp_data, b[0] ? DEV : MAKER);
    end
    // Codes by plain reads with high voltage on bit nine, no command
    u_flash.hv_id = 1'b1;
    for (int b = 0; b < 2; b++) begin
      op(4'h0, {8'h00, 1'b1, 8'h00, b[0]}, 16'h0000);
      chk(rsp_data, b[0] ? DEV : MAKER);
    end
    u_flash.hv_id = 1'b0;
  endtask
  // Protect then unprotect one sector, each followed by its verify read
  task automatic t_protect;
    for (int u = 0; u < 2; u++) begin
      op(u[0] ? 4'h9 : 4'h8, 18'h3a000, 16'h0000);
      chk_unl(0, 8'h80);
      chk_unl(3, 8'h20);
      chk({u_flash.wlog[6][25], u_flash.wlog[6][22]}, {1'b1, u[0]});
      op(4'ha, 18'h3a000, 16'h0000);
      chk(u_flash.wlog.size(), 0);
      chk(rsp_data, {15'h0000, !u[0]});
    end
  endtask
  // A forced erase time-out must end in an abort write
  task automatic t_fail;
    fail_mode = 1'b1;
    op(4'h3, 18'h10000, 16'h0000);
    fail_mode = 1'b0;
    chk(rsp_fail, 1'b1);
    chk(u_flash.wlog[u_flash.wlog.size() - 1][7:0], 8'hf0);
    chk(u_flash.mode, 0);
    op(4'h0, 18'h10000, 16'h0000);
    chk(rsp_fail, 1'b0);
  endtask
  // Main sequence after 3 cycles of reset
  initial begin
    repeat (3) @(negedge core_clk_i);
    rstn_i = 1'b1;
    t_program(1'b0, 18'h3f0f0, 16'h5a3c);
    t_program(1'b1, 18'h00a42, 16'hc3a5);
    t_erase(1'b0);
    t_single;
    t_erase(1'b1);
    t_ident;
    t_protect;
    t_fail;
    chk(u_flash.viol, 0);
    end_sim;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #2000000;
    fails++;
    end_sim;
  end
endmodule // nor_flash_host_tb_top
`default_nettype wire
